// file: acr_pkg.sv
// Constants for the converter clock, rate and reference control block.
// Assumes a single 250 MHz system clock and no register bus; bits are ports.
package acr_pkg;

  // Output rate select codes, slowest first.
  localparam logic [3:0] RATE_5    = 4'h0;
  localparam logic [3:0] RATE_10   = 4'h1;
  localparam logic [3:0] RATE_20   = 4'h2;
  localparam logic [3:0] RATE_40   = 4'h3;
  localparam logic [3:0] RATE_80   = 4'h4;
  localparam logic [3:0] RATE_160  = 4'h5;
  localparam logic [3:0] RATE_320  = 4'h6;
  localparam logic [3:0] RATE_640  = 4'h7;
  localparam logic [3:0] RATE_1000 = 4'h8;
  localparam logic [3:0] RATE_2000 = 4'h9;
  localparam logic [3:0] RATE_RST  = 4'h0;

  // Modulator divide ratios, selected source clock over modulator clock.
  localparam logic [7:0] DIV_SLOW = 8'h80;
  localparam logic [7:0] DIV_MID  = 8'h20;
  localparam logic [7:0] DIV_FAST = 8'h10;
  localparam logic [7:0] DIV_TOP  = 8'h08;

  // Modulator clocks per conversion, one entry per rate code.
  localparam logic [15:0] CONV_5    = 16'h18e9;
  localparam logic [15:0] CONV_10   = 16'h0c74;
  localparam logic [15:0] CONV_20   = 16'h063a;
  localparam logic [15:0] CONV_40   = 16'h0c74;
  localparam logic [15:0] CONV_80   = 16'h063a;
  localparam logic [15:0] CONV_160  = 16'h031d;
  localparam logic [15:0] CONV_320  = 16'h031c;
  localparam logic [15:0] CONV_640  = 16'h018e;
  localparam logic [15:0] CONV_1000 = 16'h0100;
  localparam logic [15:0] CONV_2000 = 16'h0100;

  // Edges on the clock pin needed before the external clock is trusted.
  localparam logic [3:0] EXT_EDGES = 4'h4;

  // Reference pair select, reset values of reference controls.
  localparam logic [1:0] REF_SEL_RST = 2'h0;
  localparam logic       REF_ON_RST  = 1'b0;

  // Clock selection states.
  typedef enum logic [1:0] {
    CS_INT  = 2'b00,
    CS_WAIT = 2'b01,
    CS_EXT  = 2'b10
  } acr_clk_state_t;

endpackage : acr_pkg

// file: acr_mod_div.sv
// Modulator clock divider producing a one-cycle enable pulse.
// Assumes the tick input is the selected source clock enable.
`timescale 1ns/1ps
`default_nettype none
module acr_mod_div (
  // Clock and reset.
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  // Control.
  input  wire logic       tick_i,
  input  wire logic       restart_i,
  input  wire logic [7:0] div_i,
  // Result.
  output logic            mod_en_o
);
  import acr_pkg::*;

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic       en_ff;
  logic       nxt_en;

  // Count source ticks and pulse on the last one of each period.
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_en  = 1'b0;
    if (restart_i) begin
      nxt_cnt = 8'h00;
    end else if (tick_i) begin
      if (cnt_ff >= div_i - 8'h01) begin
        nxt_cnt = 8'h00;
        nxt_en  = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= 8'h00;
      en_ff  <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      en_ff  <= nxt_en;
    end
  end

  assign mod_en_o = en_ff;
endmodule : acr_mod_div
`default_nettype wire

// file: acr_ctrl.sv
// Clock source choice, modulator rate, filter timing and reference gating.
// Assumes the oscillator and clock pin arrive as asynchronous levels that are
// sampled here; the system clock advance enables stand in for both sources.
`timescale 1ns/1ps
`default_nettype none
module acr_ctrl (
  // Clock and reset.
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  // Clock sources, sampled as levels.
  input  wire logic       clk_pin_i,
  input  wire logic       osc_tick_i,
  // Configuration.
  input  wire logic [3:0] output_rate_select_i,
  input  wire logic       int_ref_en_i,
  input  wire logic [1:0] ref_pair_sel_i,
  input  wire logic       ref_pair0_gpio_i,
  input  wire logic       start_i,
  // Status and controls out.
  output logic            ext_clk_sel_o,
  output logic            osc_en_o,
  output logic            mod_en_o,
  output logic            data_rdy_o,
  output logic            internal_ref_output_o,
  output logic            exc_avail_o,
  output logic [1:0]      ref_pair_sel_o,
  output logic            ref_pair0_dig_o
);
  import acr_pkg::*;

  // Three-stage sampling of the clock pin and oscillator; stage one feeds only stage two.
  logic pin_s1_ff;
  logic pin_s2_ff;
  logic pin_s3_ff;
  logic osc_s1_ff;
  logic osc_s2_ff;
  logic osc_s3_ff;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
    end else begin
      pin_s1_ff <= clk_pin_i;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      osc_s1_ff <= osc_tick_i;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
    end
  end

  // Rising edges of the sampled levels; stage three resets low like the
  // grounded pin, so no false edge on the pin follows reset.
  logic pin_rise;
  logic osc_rise;
  assign pin_rise = pin_s2_ff & ~pin_s3_ff;
  assign osc_rise = osc_s2_ff & ~osc_s3_ff;

  // Clock selection machine.
  acr_clk_state_t cs_ff;
  acr_clk_state_t nxt_cs;
  logic [3:0]     edge_cnt_ff;
  logic [3:0]     nxt_edge_cnt;
  logic           ext_ff;
  logic           nxt_ext;
  logic           sw_ff;
  logic           nxt_sw;
  logic           osc_ff;
  logic           nxt_osc;

  // edge count qualify.
  // A few edges must be seen before switching, so one glitch on a grounded
  // pin does not steal the clock; the swap happens on a rising edge of the pin.
  always_comb begin
    nxt_cs       = cs_ff;
    nxt_edge_cnt = edge_cnt_ff;
    nxt_ext      = ext_ff;
    nxt_sw       = 1'b0;
    case (cs_ff)
      CS_INT: begin
        nxt_ext = 1'b0;
        if (pin_rise) begin
          nxt_cs       = CS_WAIT;
          nxt_edge_cnt = 4'h1;
        end
      end
      // No timeout here: a pin that stops early leaves the count waiting,
      // which is harmless as the oscillator keeps the block running.
      // switch on activity.
      CS_WAIT: begin
        if (pin_rise) begin
          nxt_edge_cnt = edge_cnt_ff + 4'h1;
        end
        if (edge_cnt_ff >= EXT_EDGES && pin_rise) begin
          nxt_cs  = CS_EXT;
          nxt_ext = 1'b1;
          nxt_sw  = 1'b1;
        end
      end
      CS_EXT: begin
        nxt_ext = 1'b1;
      end
      default: begin
        nxt_cs  = CS_INT;
        nxt_ext = 1'b0;
      end
    endcase
    // The oscillator enable has its own register so the output is glitch-free.
    nxt_osc = ~nxt_ext;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_ff       <= CS_INT;
      edge_cnt_ff <= 4'h0;
      ext_ff      <= 1'b0;
      sw_ff       <= 1'b0;
      osc_ff      <= 1'b1;
    end else begin
      cs_ff       <= nxt_cs;
      edge_cnt_ff <= nxt_edge_cnt;
      ext_ff      <= nxt_ext;
      sw_ff       <= nxt_sw;
      osc_ff      <= nxt_osc;
    end
  end

  // Source tick: the selected clock's rising edge, one cycle wide.
  // Limitation: source edges closer than two system cycles merge into one.
  // rate follows clock.
  logic src_tick;
  assign src_tick = ext_ff ? pin_rise : osc_rise;

  logic [7:0]  div_sel;
  logic [15:0] conv_len;
  always_comb begin
    div_sel  = DIV_SLOW;
    conv_len = CONV_5;
    case (output_rate_select_i)
      RATE_5: begin
        div_sel  = DIV_SLOW;
        conv_len = CONV_5;
      end
      RATE_10: begin
        div_sel  = DIV_SLOW;
        conv_len = CONV_10;
      end
      RATE_20: begin
        div_sel  = DIV_SLOW;
        conv_len = CONV_20;
      end
      RATE_40: begin
        div_sel  = DIV_MID;
        conv_len = CONV_40;
      end
      RATE_80: begin
        div_sel  = DIV_MID;
        conv_len = CONV_80;
      end
      RATE_160: begin
        div_sel  = DIV_MID;
        conv_len = CONV_160;
      end
      RATE_320: begin
        div_sel  = DIV_FAST;
        conv_len = CONV_320;
      end
      RATE_640: begin
        div_sel  = DIV_FAST;
        conv_len = CONV_640;
      end
      RATE_1000: begin
        div_sel  = DIV_FAST;
        conv_len = CONV_1000;
      end
      RATE_2000: begin
        div_sel  = DIV_TOP;
        conv_len = CONV_2000;
      end
      default: begin
        div_sel  = DIV_SLOW;
        conv_len = CONV_5;
      end
    endcase
  end

  // ten rate codes.
  // A changed rate, a start or a clock swap restarts the divider so that
  // no shortened modulator period ever escapes.
  logic [3:0] rate_ff;
  logic       restart;
  assign restart = (rate_ff != output_rate_select_i) | start_i | sw_ff;

  // The divider pulses once per modulator period of the selected source.
  logic mod_en;
  acr_mod_div u_div (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .tick_i    (src_tick),
    .restart_i (restart),
    .div_i     (div_sel),
    .mod_en_o  (mod_en)
  );

  // Conversion period counter; a ready pulse ends each full period.
  logic [15:0] conv_cnt_ff;
  logic [15:0] nxt_conv_cnt;
  logic        rdy_ff;
  logic        nxt_rdy;
  logic        mod_ff;
  logic        nxt_mod;

  // settled first period.
  // The filter window equals one period, so the first ready after a
  // restart already carries a settled result and none is discarded.
  always_comb begin
    nxt_conv_cnt = conv_cnt_ff;
    nxt_rdy      = 1'b0;
    nxt_mod      = mod_en;
    if (restart) begin
      nxt_conv_cnt = 16'h0000;
    end else if (mod_en) begin
      if (conv_cnt_ff >= conv_len - 16'h0001) begin
        nxt_conv_cnt = 16'h0000;
        nxt_rdy      = 1'b1;
      end else begin
        nxt_conv_cnt = conv_cnt_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_cnt_ff <= 16'h0000;
      rdy_ff      <= 1'b0;
      mod_ff      <= 1'b0;
      rate_ff     <= RATE_RST;
    end else begin
      conv_cnt_ff <= nxt_conv_cnt;
      rdy_ff      <= nxt_rdy;
      mod_ff      <= nxt_mod;
      rate_ff     <= output_rate_select_i;
    end
  end

  // Reference controls, registered so outputs come from flip-flops.
  logic       ref_on_ff;
  logic       nxt_ref_on;
  logic       exc_ff;
  logic       nxt_exc;
  logic [1:0] ref_sel_ff;
  logic [1:0] nxt_ref_sel;
  logic       dig_ff;
  logic       nxt_dig;

  // The excitation enable looks at the registered reference state, so it
  // rises one cycle after the reference and falls together with it.
  always_comb begin
    nxt_ref_on  = int_ref_en_i;
    nxt_exc     = int_ref_en_i & ref_on_ff;
    nxt_ref_sel = ref_pair_sel_i;
    nxt_dig     = ref_pair0_gpio_i;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_on_ff  <= REF_ON_RST;
      exc_ff     <= 1'b0;
      ref_sel_ff <= REF_SEL_RST;
      dig_ff     <= 1'b0;
    end else begin
      ref_on_ff  <= nxt_ref_on;
      exc_ff     <= nxt_exc;
      ref_sel_ff <= nxt_ref_sel;
      dig_ff     <= nxt_dig;
    end
  end

  // Every output is taken straight from a register.
  assign ext_clk_sel_o         = ext_ff;
  assign osc_en_o              = osc_ff;
  assign mod_en_o              = mod_ff;
  assign data_rdy_o            = rdy_ff;
  assign internal_ref_output_o = ref_on_ff;
  assign exc_avail_o           = exc_ff;
  assign ref_pair_sel_o        = ref_sel_ff;
  assign ref_pair0_dig_o       = dig_ff;
endmodule : acr_ctrl
`default_nettype wire

// file: acr_ctrl_asserts.sv
// Port checker for acr_ctrl: clock choice, modulator pacing, reference gating.
// Assumes one clock domain; bound below to every acr_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
module acr_ctrl_asserts (
  // Clock and reset.
  input wire logic       clk_sys_i,
  input wire logic       arst_n_i,
  // Watched inputs.
  input wire logic       int_ref_en_i,
  input wire logic [1:0] ref_pair_sel_i,
  // Watched outputs.
  input wire logic       ext_clk_sel_o,
  input wire logic       osc_en_o,
  input wire logic       mod_en_o,
  input wire logic       data_rdy_o,
  input wire logic       internal_ref_output_o,
  input wire logic       exc_avail_o,
  input wire logic [1:0] ref_pair_sel_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // Enable raised and still held on the next edge.
  sequence s_ref_up;
    $rose(int_ref_en_i) ##1 int_ref_en_i;
  endsequence
  property p_osc_excl;
    osc_en_o != ext_clk_sel_o;
  endproperty
  a_osc_excl: assert property (p_osc_excl)
    else $error("oscillator enable does not mirror clock selection");
  property p_ext_hold;
    ext_clk_sel_o |=> ext_clk_sel_o;
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("external clock selection dropped without reset");
  property p_ref_on;
    $rose(int_ref_en_i) |=> internal_ref_output_o;
  endproperty
  a_ref_on: assert property (p_ref_on)
    else $error("reference did not turn on one cycle after enable");
  property p_exc_on;
    s_ref_up |=> exc_avail_o;
  endproperty
  a_exc_on: assert property (p_exc_on)
    else $error("excitation not available two cycles after enable");
  property p_exc_gate;
    exc_avail_o |-> internal_ref_output_o;
  endproperty
  a_exc_gate: assert property (p_exc_gate)
    else $error("excitation available with reference off");
  property p_sel_pass;
    1'b1 |=> ref_pair_sel_o == $past(ref_pair_sel_i);
  endproperty
  a_sel_pass: assert property (p_sel_pass)
    else $error("reference pair select not passed on");
  // Eight ticks of at least two cycles each lie between two pulses.
  property p_mod_gap;
    mod_en_o |=> !mod_en_o [*8];
  endproperty
  a_mod_gap: assert property (p_mod_gap)
    else $error("modulator pulses too close together");
  // Both pulses are registered from the same divider pulse, so they coincide.
  property p_rdy_mod;
    data_rdy_o |-> mod_en_o;
  endproperty
  a_rdy_mod: assert property (p_rdy_mod)
    else $error("result ready without a modulator pulse beside it");
endmodule : acr_ctrl_asserts
bind acr_ctrl acr_ctrl_asserts i_acr_ctrl_asserts (.clk_sys_i, .arst_n_i, .int_ref_en_i,
  .ref_pair_sel_i, .ext_clk_sel_o, .osc_en_o, .mod_en_o, .data_rdy_o,
  .internal_ref_output_o, .exc_avail_o, .ref_pair_sel_o);
`default_nettype wire

// file: acr_src_model.sv
// Clock sources facing acr_ctrl: internal oscillator and external clock pin.
// Assumes the bench starts and stops the external clock through ext_run_i.
`timescale 1ns/1ps
`default_nettype none
module acr_src_model (
  // Clock and control.
  input  wire logic clk_sys_i,
  input  wire logic ext_run_i,
  // Source levels.
  output logic      osc_o,
  output logic      pin_o
);
  logic [2:0] cnt_ff = 3'h0;
  // Free-running phase counter shared by both sources.
  always_ff @(posedge clk_sys_i) begin
    cnt_ff <= cnt_ff + 3'h1;
  end
  // pin grounded idle
  // The pin rests low outside external operation, so no stray edge is seen.
  assign pin_o = ext_run_i & cnt_ff[1];
  assign osc_o = cnt_ff[2];
endmodule : acr_src_model
`default_nettype wire

// file: acr_ctrl_tb.sv
// Self-checking bench for acr_ctrl driven by the clock source model.
// Assumes 250 MHz; inputs change and outputs are sampled on falling edges, except the reset checks 1 ns after one.
`timescale 1ns/1ps
`default_nettype none
module acr_ctrl_tb;
  import acr_pkg::*;
  localparam int OSC_PER = 8;
  localparam int PIN_PER = 4;
  logic       clk_sys_i, arst_n_i, ext_run, clk_pin_i, osc_tick_i;
  logic       int_ref_en_i, ref_pair0_gpio_i, start_i;
  logic [3:0] output_rate_select_i;
  logic [1:0] ref_pair_sel_i, ref_pair_sel_o;
  logic       ext_clk_sel_o, osc_en_o, mod_en_o, data_rdy_o;
  logic       internal_ref_output_o, exc_avail_o, ref_pair0_dig_o;
  logic [2:0] evt;
  int         n_errors, total_checks, n, m;
  assign evt = {ext_clk_sel_o, data_rdy_o, mod_en_o};
  acr_src_model i_acr_src_model (.clk_sys_i, .ext_run_i(ext_run), .osc_o(osc_tick_i),
    .pin_o(clk_pin_i));
  acr_ctrl i_acr_ctrl (.clk_sys_i, .arst_n_i, .clk_pin_i, .osc_tick_i, .output_rate_select_i,
    .int_ref_en_i, .ref_pair_sel_i, .ref_pair0_gpio_i, .start_i, .ext_clk_sel_o, .osc_en_o,
    .mod_en_o, .data_rdy_o, .internal_ref_output_o, .exc_avail_o, .ref_pair_sel_o,
    .ref_pair0_dig_o);
  // Free-running 4 ns clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string name, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check
  // Waits for event bit which; a hang is cut off so the run still ends cleanly.
  task automatic wait_hi(input int which, output int cyc);
    cyc = 0;
    do begin
      @(negedge clk_sys_i);
      cyc++;
    end while (evt[which] !== 1'b1 && cyc < 20000);
    if (cyc >= 20000) begin
      n_errors++;
      finish_test();
    end
  endtask : wait_hi
  task automatic t_reset;
    check("osc", osc_en_o, 1);
    check("ext", ext_clk_sel_o, 0);
    check("ref", internal_ref_output_o, 0);
    check("exc", exc_avail_o, 0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_ref;
    int_ref_en_i = 1'b1;
    @(negedge clk_sys_i);
    check("ref", internal_ref_output_o, 1);
    check("exc", exc_avail_o, 0);
    @(negedge clk_sys_i);
    check("exc", exc_avail_o, 1);
    repeat (4) @(negedge clk_sys_i);
    for (int i = 0; i < 4; i++) begin
      ref_pair_sel_i = i[1:0];
      ref_pair0_gpio_i = i[0];
      @(negedge clk_sys_i);
      check("sel", ref_pair_sel_o, i);
      check("dig", ref_pair0_dig_o, i[0]);
    end
    int_ref_en_i = 1'b0;
    @(negedge clk_sys_i);
    check("exc", exc_avail_o, 0);
    $display("reference test done");
  endtask : t_ref
  task automatic t_rate;
    logic [7:0] dv [10] = '{DIV_SLOW, DIV_SLOW, DIV_SLOW, DIV_MID, DIV_MID, DIV_MID,
                            DIV_FAST, DIV_FAST, DIV_FAST, DIV_TOP};
    // The first pulse after a rate change only resynchronises the count.
    for (int i = 0; i < 10; i++) begin
      output_rate_select_i = i[3:0];
      wait_hi(0, n);
      wait_hi(0, n);
      check("mod gap", n, dv[i] * OSC_PER);
    end
    wait_hi(1, n);
    wait_hi(1, n);
    check("rdy gap", n, CONV_2000 * DIV_TOP * OSC_PER);
    start_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    m = 0;
    repeat (200) begin
      @(negedge clk_sys_i);
      m += (mod_en_o !== 1'b0);
    end
    check("held", m, 0);
    start_i = 1'b0;
    $display("rate test done");
  endtask : t_rate
  task automatic t_ext;
    ext_run = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    ext_run = 1'b0;
    repeat (10) @(negedge clk_sys_i);
    check("few edges", ext_clk_sel_o, 0);
    ext_run = 1'b1;
    wait_hi(2, n);
    check("osc off", osc_en_o, 0);
    // A pulse already in flight at the swap is let pass before timing.
    repeat (4) @(negedge clk_sys_i);
    wait_hi(0, n);
    wait_hi(0, n);
    check("ext gap", n, DIV_TOP * PIN_PER);
    ext_run = 1'b0;
    repeat (50) @(negedge clk_sys_i);
    check("ext held", ext_clk_sel_o, 1);
    arst_n_i = 1'b0;
    #1;
    check("ext rst", ext_clk_sel_o, 0);
    check("osc rst", osc_en_o, 1);
    repeat (10) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    wait_hi(0, n);
    wait_hi(0, n);
    // The fastest rate code from the rate test is still selected.
    check("osc gap", n, DIV_TOP * OSC_PER);
    $display("clock source test done");
  endtask : t_ext
  // Reset, then the scenarios in turn.
  initial begin
    n_errors = 0;
    total_checks = 0;
    arst_n_i = 1'b0;
    ext_run = 1'b0;
    int_ref_en_i = 1'b0;
    ref_pair0_gpio_i = 1'b0;
    start_i = 1'b0;
    output_rate_select_i = RATE_RST;
    ref_pair_sel_i = REF_SEL_RST;
    repeat (10) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    @(negedge clk_sys_i);
    t_reset();
    t_ref();
    t_rate();
    t_ext();
    finish_test();
  end
endmodule : acr_ctrl_tb
`default_nettype wire
